// [bench/shift_logic_model.sv]
/*
  Model of the transmit and receive shift logic beside the rate generator:
  drives the status levels and the receive pin, and measures tick gaps.
  Assumes it runs on core_clk with the design and that the bench commands
  its levels.
*/
`default_nettype none

module shift_logic_model (
  input  wire logic                       core_clk,
  input  wire logic                       rstn,
  input  wire usart_brg_pkg::rate_ticks_t ticks,
  input  wire logic [3:0]                 status_cmd,
  input  wire logic                       pin_cmd,
  output logic                            tsr_empty,
  output logic                            frame_err,
  output logic                            overrun_err,
  output logic                            rx_ninth,
  output logic                            rx_pin,
  output logic [15:0]                     shift_gap,
  output logic [15:0]                     sample_gap
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] shift_cnt_q;
  logic [15:0] sample_cnt_q;

  assign {tsr_empty, frame_err, overrun_err, rx_ninth} = status_cmd;
  assign rx_pin = pin_cmd;

  // gaps are in clocks between successive ticks
  always_ff @(posedge core_clk)
  begin
    shift_cnt_q <= (!rstn || ticks.shift_tick) ? 16'h0001
                                               : shift_cnt_q + 16'h0001;
    if (ticks.shift_tick)
      shift_gap <= shift_cnt_q;
  end

  always_ff @(posedge core_clk)
  begin
    sample_cnt_q <= (!rstn || ticks.sample_tick) ? 16'h0001
                                                 : sample_cnt_q + 16'h0001;
    if (ticks.sample_tick)
      sample_gap <= sample_cnt_q;
  end
endmodule

`default_nettype wire

// [bench/usart_baud_rate_generator_tb.sv]
/*
  Self-checking bench of the serial port rate generator: register access,
  tick periods in the three internally clocked modes, no shift tick as slave, divisor restart and the receive sampler.
  Assumes the design files and the shift logic model are compiled first.
*/
`default_nettype none

module usart_baud_rate_generator_tb;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic [7:0]  txc;
    logic [7:0]  div;
    logic [15:0] shift;
    logic [15:0] samp;
  } row_t;

  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [3:0] status_cmd = 4'h8;
  logic pin_cmd = 1'b1;
  logic tsr_empty, frame_err, overrun_err, rx_ninth, rx_pin, rx_level;
  logic [7:0] tx_ctrl, rx_ctrl, rd_val;
  logic [15:0] shift_gap, sample_gap;
  usart_brg_pkg::rate_ticks_t ticks;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  int n;
  // sample gap 0 marks a synchronous row, where no sample tick is made
  row_t rows [7] = '{
    '{8'h00, 8'h00, 16'h0040, 16'h0001},
    '{8'h00, 8'h01, 16'h0080, 16'h0002},
    '{8'h04, 8'h02, 16'h0030, 16'h0003},
    '{8'h04, 8'hff, 16'h1000, 16'h0100},
    '{8'h90, 8'h03, 16'h0010, 16'h0000},
    '{8'h94, 8'h03, 16'h0010, 16'h0000},
    '{8'h90, 8'hff, 16'h0400, 16'h0000}
  };

  usart_baud_rate_generator dut (
    .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .tsr_empty(tsr_empty), .frame_err(frame_err),
    .overrun_err(overrun_err), .rx_ninth(rx_ninth),
    .shared_receive_pin(rx_pin), .tx_ctrl(tx_ctrl), .rx_ctrl(rx_ctrl),
    .ticks(ticks), .rx_level(rx_level));

  shift_logic_model partner (
    .core_clk(core_clk), .rstn(rstn), .ticks(ticks),
    .status_cmd(status_cmd), .pin_cmd(pin_cmd), .tsr_empty(tsr_empty),
    .frame_err(frame_err), .overrun_err(overrun_err), .rx_ninth(rx_ninth),
    .rx_pin(rx_pin), .shift_gap(shift_gap), .sample_gap(sample_gap));

  initial
  begin
    forever #10 core_clk = ~core_clk;
  end

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // n = clocks until a shift tick; bounded so a dead timer cannot hang
  task automatic wait_shift(input int lim);
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end while (ticks.shift_tick !== 1'b1 && n < lim);
    #1;
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      num_errors++;
      give_verdict();
    end
  end

  initial
  begin
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    rd(8'h98, rd_val);
    chk("tx reset", 16'h0002, {8'h00, rd_val});
    chk("tx reset out", 16'h0002, {8'h00, tx_ctrl});
    chk("rx reset out", 16'h0000, {8'h00, rx_ctrl});
    rd(8'h99, rd_val);
    chk("div reset", 16'h0000, {8'h00, rd_val});
    #20 chk("rdata idle", 16'h0000, {8'h00, reg_rdata});
    status_cmd <= 4'hd;
    wr(8'h18, 8'hff);
    rd(8'h18, rd_val);
    chk("rx ctrl", 16'h00fd, {8'h00, rd_val});
    wr(8'h98, 8'hff);
    rd(8'h98, rd_val);
    chk("tx ctrl", 16'h00f7, {8'h00, rd_val});
    chk("tx ctrl out", 16'h00f5, {8'h00, tx_ctrl});
    chk("rx ctrl out", 16'h00f8, {8'h00, rx_ctrl});
    wr(8'h99, 8'ha5);
    rd(8'h99, rd_val);
    chk("divisor", 16'h00a5, {8'h00, rd_val});
    // write strobe followed at once by a read strobe, no idle cycle
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= 8'h99;
    reg_wdata <= 8'h5a;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk("wr then rd", 16'h005a, {8'h00, reg_rdata});
    rd(8'h42, rd_val);
    chk("unmapped", 16'h0000, {8'h00, rd_val});
    $display("register test done");

    foreach (rows[i])
    begin
      wr(8'h98, rows[i].txc);
      wr(8'h99, rows[i].div);
      wait_shift(20000);
      wait_shift(20000);
      chk("shift seen", 16'h0001, {15'h0000, n < 20000});
      chk("shift gap", rows[i].shift, shift_gap);
      if (rows[i].samp != 16'h0000)
        chk("sample gap", rows[i].samp, sample_gap);
      $display("rate row %0d done", i);
    end

    wr(8'h98, 8'h10);
    wr(8'h99, 8'h00);
    wait_shift(300);
    chk("slave tick", 16'h0000, {15'h0000, n < 300});
    $display("slave test done");

    wr(8'h98, 8'h04);
    wr(8'h99, 8'hff);
    repeat (100) @(posedge core_clk);
    wr(8'h99, 8'h00);
    wait_shift(5000);
    chk("restart", 16'h0012, n[15:0]);
    $display("restart test done");

    @(posedge core_clk);
    pin_cmd <= 1'b0;
    @(posedge core_clk);
    pin_cmd <= 1'b1;
    repeat (10) @(posedge core_clk);
    chk("glitch level", 16'h0001, {15'h0000, rx_level});
    pin_cmd <= 1'b0;
    repeat (8) @(posedge core_clk);
    chk("low level", 16'h0000, {15'h0000, rx_level});
    $display("sampler test done");
    give_verdict();
  end
endmodule

`default_nettype wire

// [hdl/divisor_timer.sv]
/*
  Free-running reloadable timer: one tick every divisor+1 clocks.
  Assumes clear and divisor come from logic on the same clock.
*/
`default_nettype none

module divisor_timer #(
  parameter int DIV_WIDTH = 8
) (
  input  wire logic                 core_clk,
  input  wire logic                 rstn,
  input  wire logic                 clear,
  input  wire logic [DIV_WIDTH-1:0] divisor,
  output logic                      tick
);

  logic [DIV_WIDTH-1:0] count_q;
  logic                 tick_q;

  if (DIV_WIDTH < 1 || DIV_WIDTH > 16)
  begin : g_width_check
    $error("divisor_timer: DIV_WIDTH out of range");
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      count_q <= '0;
    else if (clear)
      count_q <= '0;
    else if (count_q == divisor)
      count_q <= '0;
    else
      count_q <= count_q + 1'b1;
  end

  // a tick pending in the write cycle is dropped so the new rate starts clean
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      tick_q <= 1'b0;
    else
      tick_q <= !clear && (count_q == divisor);
  end

  assign tick = tick_q;

endmodule

`default_nettype wire

// [hdl/majority_sampler.sv]
/*
  Receive pin synchroniser and three-sample majority vote.
  Assumes rx_pin is asynchronous; sample_en is a one-cycle pulse.
*/
`default_nettype none

module majority_sampler (
  input  wire logic core_clk,
  input  wire logic rstn,
  input  wire logic rx_pin,
  input  wire logic sample_en,
  output logic      rx_level
);

  logic       sync1_q;
  logic       sync2_q;
  logic [2:0] samples_q;
  logic       level_q;

  // idle line is high, so samples reset high to avoid a false start bit
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end
    else
    begin
      sync1_q <= rx_pin;
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      samples_q <= 3'h7;
    else if (sample_en)
      samples_q <= {samples_q[1:0], sync2_q};
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      level_q <= 1'b1;
    else
      level_q <= (samples_q[0] & samples_q[1]) | (samples_q[0] & samples_q[2])
               | (samples_q[1] & samples_q[2]);
  end

  assign rx_level = level_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  majority_high_a : assert property (
    $countones(samples_q) >= 2 |=> level_q)
    else $error("majority of samples high but level low");

  majority_low_a : assert property (
    $countones(samples_q) < 2 |=> !level_q)
    else $error("majority of samples low but level high");

endmodule

`default_nettype wire

// [hdl/usart_baud_rate_generator.sv]
/*
  Serial port rate generator: register file, divisor timer, post-divider
  for the shift rate and the receive pin majority sampler.
  Assumes a register master on core_clk with one-cycle strobes, and
  transmit/receive shift logic on the same clock using the tick outputs.
*/
`default_nettype none

`include "usart_brg_map.svh"

module usart_baud_rate_generator #(
  parameter int ADDR_W = 8
) (
  input  wire logic              core_clk,
  input  wire logic              rstn,
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  input  wire logic              tsr_empty,
  input  wire logic              frame_err,
  input  wire logic              overrun_err,
  input  wire logic              rx_ninth,
  input  wire logic              shared_receive_pin,
  output logic      [7:0]        tx_ctrl,
  output logic      [7:0]        rx_ctrl,
  output usart_brg_pkg::rate_ticks_t ticks,
  output logic                   rx_level
);

  logic [7:0]                transmit_status_control_q;
  logic [7:0]                receive_status_control_q;
  logic [7:0]                baud_divisor_reg_q;
  logic [7:0]                rdata_q;
  logic [7:0]                rdata_d;
  logic                      div_wr;
  logic                      tx_wr;
  logic                      rx_wr;
  logic                      sync_sel;
  logic                      high_speed_select;
  logic                      master_sel;
  usart_brg_pkg::rate_mode_t mode;
  usart_brg_pkg::rate_mode_t mode_q;
  logic                      mode_chg;
  logic                      timer_tick;
  logic [5:0]                post_q;
  logic [5:0]                post_last;
  logic                      wrap;
  usart_brg_pkg::rate_ticks_t ticks_q;

  if (ADDR_W < 8)
  begin : g_addr_check
    $error("usart_baud_rate_generator: ADDR_W must be at least 8");
  end

  assign div_wr = reg_wr && (reg_addr == ADDR_W'(`OFF_DIVISOR));
  assign tx_wr  = reg_wr && (reg_addr == ADDR_W'(`OFF_TX_CTRL));
  assign rx_wr  = reg_wr && (reg_addr == ADDR_W'(`OFF_RX_CTRL));

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      baud_divisor_reg_q <= `RST_DIVISOR;
    else if (div_wr)
      baud_divisor_reg_q <= reg_wdata;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      transmit_status_control_q <= `RST_TX_CTRL;
    else if (tx_wr)
      transmit_status_control_q <= reg_wdata & `TX_WR_MASK;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      receive_status_control_q <= `RST_RX_CTRL;
    else if (rx_wr)
      receive_status_control_q <= reg_wdata & `RX_WR_MASK;
  end

  // status bits owned by the shift logic are read live, never stored here
  always_comb
  begin
    rdata_d = 8'h00;
    if (!reg_rd)
      rdata_d = 8'h00;
    else if (reg_addr == ADDR_W'(`OFF_DIVISOR))
      rdata_d = baud_divisor_reg_q;
    else if (reg_addr == ADDR_W'(`OFF_TX_CTRL))
    begin
      rdata_d = transmit_status_control_q & `TX_WR_MASK;
      rdata_d[`TXC_TSR_BIT] = tsr_empty;
    end
    else if (reg_addr == ADDR_W'(`OFF_RX_CTRL))
      rdata_d = (receive_status_control_q & `RX_WR_MASK)
              | {5'h00, frame_err, overrun_err, rx_ninth};
    else
      rdata_d = 8'h00;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      rdata_q <= 8'h00;
    else
      rdata_q <= rdata_d;
  end

  assign sync_sel          = transmit_status_control_q[`TXC_SYNC_BIT];
  assign high_speed_select = transmit_status_control_q[`TXC_HIGH_BIT];
  assign master_sel        = transmit_status_control_q[`TXC_MASTER_BIT];

  always_comb
  begin
    mode = usart_brg_pkg::MODE_ASYNC_LOW;
    if (!sync_sel)
      mode = high_speed_select ? usart_brg_pkg::MODE_ASYNC_HIGH
                               : usart_brg_pkg::MODE_ASYNC_LOW;
    else
      mode = master_sel ? usart_brg_pkg::MODE_SYNC_MASTER
                        : usart_brg_pkg::MODE_SYNC_SLAVE;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      mode_q <= usart_brg_pkg::MODE_ASYNC_LOW;
    else
      mode_q <= mode;
  end

  assign mode_chg = (mode != mode_q);

  // one timer for every mode; the post-divider ratio and the gating of the two ticks differ
  divisor_timer #(
    .DIV_WIDTH (8)
  ) u_timer (
    .core_clk (core_clk),
    .rstn     (rstn),
    .clear    (div_wr),
    .divisor  (baud_divisor_reg_q),
    .tick     (timer_tick)
  );

  always_comb
  begin
    post_last = `POST_LAST_LOW;
    case (mode)
      usart_brg_pkg::MODE_ASYNC_LOW:   post_last = `POST_LAST_LOW;
      usart_brg_pkg::MODE_ASYNC_HIGH:  post_last = `POST_LAST_HIGH;
      usart_brg_pkg::MODE_SYNC_MASTER: post_last = `POST_LAST_SYNC;
      usart_brg_pkg::MODE_SYNC_SLAVE:  post_last = `POST_LAST_SYNC;
      default:                         post_last = `POST_LAST_LOW;
    endcase
  end

  // greater-or-equal guards against a shorter ratio chosen mid-count
  assign wrap = timer_tick && (post_q >= post_last) && !div_wr && !mode_chg;

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      post_q <= 6'h00;
    else if (div_wr || mode_chg)
      post_q <= 6'h00;
    else if (timer_tick)
      post_q <= (post_q >= post_last) ? 6'h00 : post_q + 6'h01;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      ticks_q <= '0;
    else
    begin
      ticks_q.shift_tick  <= wrap && (mode != usart_brg_pkg::MODE_SYNC_SLAVE);
      ticks_q.sample_tick <= timer_tick && !sync_sel;
    end
  end

  majority_sampler u_sampler (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .rx_pin    (shared_receive_pin),
    .sample_en (timer_tick),
    .rx_level  (rx_level)
  );

  assign reg_rdata = rdata_q;
  assign tx_ctrl   = transmit_status_control_q;
  assign rx_ctrl   = receive_status_control_q;
  assign ticks     = ticks_q;

  // helper counters that only the checks below read
  logic [8:0] gap_q;
  logic       dirty_q;
  logic [6:0] tk_q;
  logic [6:0] ratio_q;

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      gap_q   <= 9'h000;
      dirty_q <= 1'b1;
    end
    else
    begin
      gap_q   <= (div_wr || timer_tick) ? 9'h000 : gap_q + 9'h001;
      dirty_q <= div_wr ? 1'b1 : (timer_tick ? 1'b0 : dirty_q);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      tk_q <= 7'h00;
    else if (div_wr || mode_chg)
      tk_q <= 7'h00;
    else
      tk_q <= (ticks_q.shift_tick ? 7'h00 : tk_q) + {6'h00, timer_tick};
  end

  always_comb
  begin
    ratio_q = `RATIO_LOW;
    case (mode_q)
      usart_brg_pkg::MODE_ASYNC_HIGH:  ratio_q = `RATIO_HIGH;
      usart_brg_pkg::MODE_SYNC_MASTER: ratio_q = `RATIO_SYNC;
      usart_brg_pkg::MODE_SYNC_SLAVE:  ratio_q = `RATIO_SYNC;
      default:                         ratio_q = `RATIO_LOW;
    endcase
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence div_write_s;
    reg_wr && (reg_addr == ADDR_W'(`OFF_DIVISOR));
  endsequence

  sequence div_read_s;
    reg_rd && (reg_addr == ADDR_W'(`OFF_DIVISOR)) && !reg_wr;
  endsequence

  tick_period_a : assert property (
    timer_tick && !dirty_q |-> gap_q == {1'b0, baud_divisor_reg_q})
    else $error("timer tick period differs from divisor plus one");

  clear_restart_a : assert property (
    timer_tick && dirty_q |-> gap_q == {1'b0, baud_divisor_reg_q} + 9'h001)
    else $error("first tick after divisor write is late or early");

  write_no_tick_a : assert property (
    div_write_s |=> !timer_tick)
    else $error("tick seen right after a divisor write");

  async_low_a : assert property (
    ticks_q.shift_tick && mode_q == usart_brg_pkg::MODE_ASYNC_LOW
    |-> tk_q == `RATIO_LOW)
    else $error("low-speed shift tick is not every 64 timer ticks");

  async_high_a : assert property (
    ticks_q.shift_tick && mode_q == usart_brg_pkg::MODE_ASYNC_HIGH
    |-> tk_q == `RATIO_HIGH)
    else $error("high-speed shift tick is not every 16 timer ticks");

  sync_div4_a : assert property (
    ticks_q.shift_tick && mode_q == usart_brg_pkg::MODE_SYNC_MASTER
    |-> tk_q == ratio_q)
    else $error("synchronous shift tick is not every 4 timer ticks");

  slave_silent_a : assert property (
    mode_q == usart_brg_pkg::MODE_SYNC_SLAVE [*2] |=> !ticks_q.shift_tick)
    else $error("shift tick produced with an outside clock");

  async_sample_a : assert property (
    timer_tick && !sync_sel |=> ticks_q.sample_tick)
    else $error("sample tick missing in asynchronous mode");

  sync_no_sample_a : assert property (
    mode_q == usart_brg_pkg::MODE_SYNC_MASTER
    || mode_q == usart_brg_pkg::MODE_SYNC_SLAVE |-> !ticks_q.sample_tick)
    else $error("sample tick produced in synchronous mode");

  // sample rate is an exact multiple of the shift rate, so ticks coincide
  shift_on_sample_a : assert property (
    ticks_q.shift_tick && (mode_q == usart_brg_pkg::MODE_ASYNC_LOW
                           || mode_q == usart_brg_pkg::MODE_ASYNC_HIGH)
    |-> ticks_q.sample_tick)
    else $error("asynchronous shift tick not on a sample tick");

  divisor_read_a : assert property (
    div_write_s ##1 div_read_s |=> reg_rdata == $past(reg_wdata, 2))
    else $error("divisor read back differs from value written");

endmodule

`default_nettype wire

// [hdl/usart_brg_map.svh]
/*
  Register offsets, field positions, reset values and divide ratios of the
  serial port rate generator.
  Assumes it is included by bare name, once per compilation unit or more.
*/
`ifndef USART_BRG_MAP_SVH
`define USART_BRG_MAP_SVH

`define OFF_RX_CTRL       8'h18
`define OFF_TX_CTRL       8'h98
`define OFF_DIVISOR       8'h99

`define RST_RX_CTRL       8'h00
`define RST_TX_CTRL       8'h02
`define RST_DIVISOR       8'h00

`define TXC_MASTER_BIT    7
`define TXC_SYNC_BIT      4
`define TXC_HIGH_BIT      2
`define TXC_TSR_BIT       1
`define TX_WR_MASK        8'hf5
`define RX_WR_MASK        8'hf8

`define POST_LAST_LOW     6'h3f
`define POST_LAST_HIGH    6'h0f
`define POST_LAST_SYNC    6'h03
`define RATIO_LOW         7'h40
`define RATIO_HIGH        7'h10
`define RATIO_SYNC        7'h04

`endif

// [hdl/usart_brg_pkg.sv]
/*
  Types shared by the rate generator files.
  Assumes the map header supplies all numeric constants.
*/
`default_nettype none

package usart_brg_pkg;

  typedef enum logic [1:0] {
    MODE_ASYNC_LOW   = 2'b00,
    MODE_ASYNC_HIGH  = 2'b01,
    MODE_SYNC_MASTER = 2'b10,
    MODE_SYNC_SLAVE  = 2'b11
  } rate_mode_t;

  typedef struct packed {
    logic sample_tick;
    logic shift_tick;
  } rate_ticks_t;

endpackage

`default_nettype wire
